// ### test/amb_core_properties.sv
// Port checks of the converter bus interface.
module amb_core_properties #(
	parameter int unsigned CONV_CYC = 36
) (
	input wire logic       clk_i,
	input wire logic       srst_i,
	input wire logic       chip_select_n_i,
	input wire logic       write_strobe_n_i,
	input wire logic       read_strobe_n_i,
	input wire logic [7:0] bus_data_lines_o,
	input wire logic       bus_data_lines_oe_o,
	input wire logic       conversion_done_n_o
);
	// Pins pass two flops, so the windows leave a few edges of slack.
	localparam int LO = CONV_CYC / 2;
	localparam int HI = CONV_CYC + 8;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	AST_OE_ON: assert property ((!chip_select_n_i && !read_strobe_n_i) [*5] |-> bus_data_lines_oe_o)
		else $error("data not driven in read");
	AST_OE_OFF: assert property ((chip_select_n_i || read_strobe_n_i) [*5] |-> !bus_data_lines_oe_o)
		else $error("data driven outside read");
	AST_OE_DONE: assert property ($rose(bus_data_lines_oe_o) |-> conversion_done_n_o)
		else $error("done low as read began");
	AST_DATA_HOLD: assert property (bus_data_lines_oe_o && $past(bus_data_lines_oe_o) |-> $stable(bus_data_lines_o))
		else $error("read data moved");
	AST_WR_DONE: assert property (
		$fell(write_strobe_n_i) && !chip_select_n_i ##1 !write_strobe_n_i [*3] |=> conversion_done_n_o)
		else $error("done not raised by write");
	AST_DONE_HOLD: assert property (
		(!conversion_done_n_o && read_strobe_n_i && write_strobe_n_i) [*4] |=> !conversion_done_n_o)
		else $error("done rose without read");
	AST_CONV_TIME: assert property (
		$rose(write_strobe_n_i) && !chip_select_n_i && read_strobe_n_i |-> ##[LO:HI] $fell(conversion_done_n_o))
		else $error("conversion late");
	AST_CONV_MIN: assert property (
		$rose(write_strobe_n_i) && !chip_select_n_i && read_strobe_n_i |=> conversion_done_n_o [*8])
		else $error("conversion too short");
endmodule // amb_core_properties

// ### test/amb_core_test.sv
// Self-checking bench of the converter bus interface.
module amb_core_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned CC = 36;
	logic                  clk_i;
	logic                  srst_i;
	amb_pkg::amb_axi_req_t rq;
	amb_pkg::amb_axi_rsp_t rs;
	amb_pkg::amb_analog_t  an;
	logic                  cs_n;
	logic                  wr_n;
	logic                  rd_n;
	logic [7:0]            hd;
	logic [7:0]            dd;
	logic                  doe;
	logic                  done_n;
	logic                  irq;
	logic [7:0]            v;
	int                    bad_count;
	int                    compares;
	// Mux address in the top five bits, expected code in the low byte.
	logic [12:0]           rows [14] = '{13'h0000, 13'h0180, 13'h0200, 13'h0310, 13'h0980, 13'h040b, 13'h058b,
		13'h062b, 13'h073b, 13'h0c00, 13'h0d50, 13'h0e00, 13'h0f00, 13'h158b};
	// A released bus with read low shows the inverse of the host's value, never a stale result.
	wire  [7:0]            bus = doe ? dd : (rd_n ? hd : ~hd);
	amb_core #(.CONV_CYC(CC)) u_amb_core (.clk_i(clk_i), .srst_i(srst_i), .axi_req_i(rq), .axi_rsp_o(rs),
		.chip_select_n_i(cs_n), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .bus_data_lines_i(bus),
		.bus_data_lines_o(dd), .bus_data_lines_oe_o(doe), .analog_i(an), .conversion_done_n_o(done_n), .irq_o(irq));
	amb_host u_amb_host (.bus_i(bus), .clk_i(clk_i), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .d_o(hd));
	always #2.5 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] wd, input logic err);
		logic aw;
		logic w;
		aw = 1'b1;
		w  = 1'b1;
		rq.awaddr  <= a;
		rq.wdata   <= wd;
		rq.wstrb   <= 4'hf;
		rq.awvalid <= 1'b1;
		rq.wvalid  <= 1'b1;
		rq.bready  <= 1'b1;
		while (aw || w) begin
			@(posedge clk_i);
			if (aw && rs.awready) begin
				aw = 1'b0;
				rq.awvalid <= 1'b0;
			end
			if (w && rs.wready) begin
				w = 1'b0;
				rq.wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge clk_i);
		end while (rs.bvalid !== 1'b1);
		rq.bready <= 1'b0;
		chk(rs.bresp, err ? amb_pkg::RESP_SLVERR : amb_pkg::RESP_OKAY);
		@(posedge clk_i);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic err);
		rq.araddr  <= a;
		rq.arvalid <= 1'b1;
		rq.rready  <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (rs.arready !== 1'b1);
		rq.arvalid <= 1'b0;
		do begin
			@(posedge clk_i);
		end while (rs.rvalid !== 1'b1);
		rq.rready <= 1'b0;
		chk(rs.rdata, ed);
		chk(rs.rresp, err ? amb_pkg::RESP_SLVERR : amb_pkg::RESP_OKAY);
		@(posedge clk_i);
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (done_n !== 1'b0 && n < 2 * CC + 20) begin
			@(posedge clk_i);
			n++;
		end
		chk(done_n, 1'h0);
	endtask
	task automatic irq_is(input logic e);
		repeat (3) @(posedge clk_i);
		chk(irq, e);
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		end_of_test();
	end
	initial begin
		clk_i     = 1'b0;
		srst_i    = 1'b1;
		rq        = '0;
		an        = 40'h4030901005;
		bad_count = 0;
		compares  = 0;
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		chk(done_n, 1'h1);
		chk(doe, 1'h0);
		chk(irq, 1'h0);
		axr(amb_pkg::OFF_CTRL, 32'h1, 1'b0);
		axr(amb_pkg::OFF_MASK, 32'h0, 1'b0);
		axr(amb_pkg::OFF_STAT, 32'h0, 1'b0);
		axr(8'h10, 32'h0, 1'b1);
		axw(8'h10, 32'h1, 1'b1);
		foreach (rows[i]) begin
			u_amb_host.start(rows[i][12:8], 1'b0, v);
			wait_done();
			u_amb_host.fetch(v);
			chk(v, rows[i][7:0]);
			chk(done_n, 1'h1);
		end
		axr(amb_pkg::OFF_STAT, 32'h7, 1'b0);
		axw(amb_pkg::OFF_MASK, 32'h1, 1'b0);
		irq_is(1'b1);
		axw(amb_pkg::OFF_STAT, 32'h1, 1'b0);
		irq_is(1'b0);
		axw(amb_pkg::OFF_MASK, 32'h2, 1'b0);
		irq_is(1'b1);
		axw(amb_pkg::OFF_MASK, 32'h0, 1'b0);
		irq_is(1'b0);
		axr(amb_pkg::OFF_STAT, 32'h6, 1'b0);
		u_amb_host.start(5'h05, 1'b0, v);
		wait_done();
		u_amb_host.start(5'h15, 1'b0, v);
		chk(done_n, 1'h1);
		wait_done();
		u_amb_host.fetch(v);
		chk(v, 8'h8b);
		axw(amb_pkg::OFF_STATE, 32'h0, 1'b0);
		axr(amb_pkg::OFF_STATE, 32'h0002158b, 1'b0);
		u_amb_host.start(5'h02, 1'b1, v);
		chk(v, 8'h8b);
		repeat (60) @(posedge clk_i);
		u_amb_host.fetch(v);
		chk(v, 8'h8b);
		axr(amb_pkg::OFF_STATE, 32'h0002158b, 1'b0);
		end_of_test();
	end
endmodule // amb_core_test

bind amb_core amb_core_properties #(.CONV_CYC(CONV_CYC)) u_amb_core_properties (.clk_i, .srst_i, .chip_select_n_i,
	.write_strobe_n_i, .read_strobe_n_i, .bus_data_lines_o, .bus_data_lines_oe_o, .conversion_done_n_o);

// ### test/amb_host.sv
// Microprocessor bus model that drives the converter's strobes.
module amb_host (
	input  wire logic [7:0] bus_i,
	input  wire logic       clk_i,
	output logic            cs_n_o,
	output logic            wr_n_o,
	output logic            rd_n_o,
	output logic [7:0]      d_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n_o = 1'b1;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		d_o    = 8'h00;
	end
	// With hold_rd the read strobe stays low for the whole write pulse.
	task automatic start(input logic [4:0] a, input logic hold_rd, output logic [7:0] seen);
		cs_n_o <= 1'b0;
		rd_n_o <= ~hold_rd;
		d_o    <= {3'h0, a};
		wr_n_o <= 1'b0;
		repeat (6) @(posedge clk_i);
		seen = bus_i;
		wr_n_o <= 1'b1;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		@(posedge clk_i);
	endtask
	// Reading before the flag falls may leave it low.
	task automatic fetch(output logic [7:0] v);
		repeat (120) @(posedge clk_i);
		cs_n_o <= 1'b0;
		rd_n_o <= 1'b0;
		repeat (6) @(posedge clk_i);
		v = bus_i;
		cs_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		@(posedge clk_i);
	endtask
endmodule // amb_host

// ### verilog/amb_core.sv
// Bus control, conversion sequencer and register slave of the eight-bit converter.
// Operation
// - Low data lines are taken as mux address only while the read strobe is high.
// - Conversion done stays low until a read, or a write strobe falling with chip select low, raises it.
// - Write strobe falling with chip select low raises conversion done and arms a cycle.
// - Write strobe rising with read high latches the mux address and starts converting.
// - Read low across the whole write pulse keeps configuration and shows the old result.
// - At most 40 us after start the result is latched and done goes low.
// - Chip select and read both low raise done and put the result on the data lines.
// - The latched address picks differential, single-ended or pseudo-differential mode.
// - Differential: bit 1 picks the pair, bit 0 picks which input is positive.
// - Single-ended: bits 1:0 pick the positive input against the ground reference.
// - Pseudo-differential: bits 1:0 pick input 1 to 3 against input 4.
// - A positive input below the negative input converts to all zeros.
// - The result is an eight-bit code with 256 steps over the reference span.
// - The positive input is sampled, the negative one half an internal period later.
module amb_core #(
	parameter int unsigned CONV_CYC = amb_pkg::CONV_CYCLES
) (
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	input  wire amb_pkg::amb_axi_req_t axi_req_i,
	output amb_pkg::amb_axi_rsp_t      axi_rsp_o,
	input  wire logic                  chip_select_n_i,
	input  wire logic                  write_strobe_n_i,
	input  wire logic                  read_strobe_n_i,
	input  wire logic [7:0]            bus_data_lines_i,
	output logic [7:0]                 bus_data_lines_o,
	output logic                       bus_data_lines_oe_o,
	input  wire amb_pkg::amb_analog_t  analog_i,
	output logic                       conversion_done_n_o,
	output logic                       irq_o
);

	localparam int unsigned HALF_RAW = CONV_CYC / (2 * amb_pkg::SAR_PERIODS);
	localparam logic [15:0] HALF_C   = 16'((HALF_RAW < 1) ? 1 : HALF_RAW);
	localparam logic [15:0] PER_C    = 16'(2 * ((HALF_RAW < 1) ? 1 : HALF_RAW));

	typedef struct packed {
		logic                  cs_n;
		logic                  wr_n;
		logic                  rd_n;
		logic [4:0]            addr_in;
		logic [4:0]            addr;
		logic                  wr_act;
		logic                  rd_low_all;
		amb_pkg::amb_state_t   st;
		logic [15:0]           cnt;
		logic [2:0]            bitn;
		logic [7:0]            pos;
		logic [7:0]            neg;
		logic [7:0]            code;
		logic [7:0]            result;
		logic                  done_n;
		logic [7:0]            db;
		logic                  db_oe;
		logic                  ctrl_en;
		logic [2:0]            stat;
		logic [2:0]            mask;
		logic                  irq;
		logic                  aw_got;
		logic [7:0]            awaddr;
		logic                  w_got;
		logic [31:0]           wdata;
		logic [3:0]            wstrb;
		amb_pkg::amb_axi_rsp_t rsp;
	} amb_core_state_t;

	amb_core_state_t q;
	amb_core_state_t d;

	logic [amb_pkg::SYNC_W-1:0] sync_q;
	logic                       cs_s;
	logic                       wr_s;
	logic                       rd_s;
	logic [7:0]                 db_s;
	amb_pkg::amb_analog_t       an_s;
	logic [2:0]                 pos_sel;
	logic [2:0]                 neg_sel;

	// Picks the synchronised level of one input or of the ground reference.
	function automatic logic [7:0] pick(input amb_pkg::amb_analog_t a, input logic [2:0] s);
		pick = (s == amb_pkg::SEL_GND) ? a.gnd : a.ch[s[1:0]];
	endfunction

	amb_sync #(
		.W   (amb_pkg::SYNC_W),
		.RST (amb_pkg::SYNC_RST)
	) u_sync (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.d_i    ({chip_select_n_i, write_strobe_n_i, read_strobe_n_i, bus_data_lines_i, analog_i}),
		.q_o    (sync_q)
	);

	assign {cs_s, wr_s, rd_s, db_s, an_s} = sync_q;

	amb_mux_decode u_decode (
		.mux_address_bits_i (q.addr),
		.pos_sel_o          (pos_sel),
		.neg_sel_o          (neg_sel)
	);

	logic                  fall_wr;
	logic                  rise_wr;
	logic                  read_on;
	logic [2:0]            ev;
	logic [7:0]            diff;
	logic [7:0]            trial;
	logic [amb_pkg::EV_W-1:0] wclr;

	always_comb begin
		d       = q;
		ev      = '0;
		wclr    = '0;
		fall_wr = q.wr_n & ~wr_s;
		rise_wr = ~q.wr_n & wr_s;
		read_on = ~cs_s & ~rd_s;
		diff    = (q.pos > q.neg) ? 8'(q.pos - q.neg) : 8'h00;
		trial   = q.code | 8'(8'h01 << q.bitn);
		d.cs_n  = cs_s;
		d.wr_n  = wr_s;
		d.rd_n  = rd_s;

		// The shared lines carry data while read is low, so they are ignored then.
		if (rd_s) begin
			d.addr_in = db_s[4:0];
		end

		if (fall_wr && !cs_s) begin
			d.wr_act     = 1'b1;
			d.rd_low_all = ~rd_s;
			d.done_n     = 1'b1;
		end else if (q.wr_act && rd_s) begin
			d.rd_low_all = 1'b0;
		end

		// Reading clears the flag before the sequencer below may set it again.
		if (read_on) begin
			d.done_n = 1'b1;
			if (!q.db_oe) begin
				ev[amb_pkg::EV_READ] = 1'b1;
			end
		end
		d.db_oe = read_on;
		d.db    = q.result;

		unique case (q.st)
			amb_pkg::ST_IDLE: begin
			end
			amb_pkg::ST_SAMPLE: begin
				d.cnt = 16'(q.cnt + 16'h0001);
				if (q.cnt == 16'h0000) begin
					d.pos = pick(an_s, pos_sel);
				end
				if (q.cnt == HALF_C) begin
					d.neg = pick(an_s, neg_sel);
				end
				if (q.cnt == 16'(PER_C - 16'h0001)) begin
					d.st   = amb_pkg::ST_RESOLVE;
					d.cnt  = '0;
					d.bitn = 3'h7;
					d.code = 8'h00;
				end
			end
			amb_pkg::ST_RESOLVE: begin
				d.cnt = 16'(q.cnt + 16'h0001);
				if (q.cnt == 16'(PER_C - 16'h0001)) begin
					d.cnt = '0;
					if (trial <= diff) begin
						d.code = trial;
					end
					if (q.bitn == 3'h0) begin
						d.st = amb_pkg::ST_LOAD;
					end else begin
						d.bitn = 3'(q.bitn - 3'h1);
					end
				end
			end
			amb_pkg::ST_LOAD: begin
				d.result            = q.code;
				d.done_n            = 1'b0;
				d.st                = amb_pkg::ST_IDLE;
				ev[amb_pkg::EV_DONE] = 1'b1;
			end
		endcase

		// A new start takes over any conversion still in progress.
		if (rise_wr && q.wr_act) begin
			d.wr_act = 1'b0;
			if (!(q.rd_low_all && !rd_s)) begin
				d.addr = q.addr_in;
			end
			if (q.ctrl_en) begin
				d.st                  = amb_pkg::ST_SAMPLE;
				d.cnt                 = '0;
				ev[amb_pkg::EV_START] = 1'b1;
			end
		end

		if (q.rsp.bvalid && axi_req_i.bready) begin
			d.rsp.bvalid = 1'b0;
		end
		if (q.rsp.awready && axi_req_i.awvalid) begin
			d.aw_got = 1'b1;
			d.awaddr = axi_req_i.awaddr;
		end
		if (q.rsp.wready && axi_req_i.wvalid) begin
			d.w_got = 1'b1;
			d.wdata = axi_req_i.wdata;
			d.wstrb = axi_req_i.wstrb;
		end
		if (d.aw_got && d.w_got && !q.rsp.bvalid) begin
			d.aw_got     = 1'b0;
			d.w_got      = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp  = amb_pkg::RESP_OKAY;
			unique case (d.awaddr)
				amb_pkg::OFF_CTRL: begin
					if (d.wstrb[0]) begin
						d.ctrl_en = d.wdata[amb_pkg::CTRL_EN_BIT];
					end
				end
				amb_pkg::OFF_STAT: begin
					if (d.wstrb[0]) begin
						wclr = d.wdata[amb_pkg::EV_W-1:0];
					end
				end
				amb_pkg::OFF_MASK: begin
					if (d.wstrb[0]) begin
						d.mask = d.wdata[amb_pkg::EV_W-1:0];
					end
				end
				amb_pkg::OFF_STATE: begin
				end
				default: begin
					d.rsp.bresp = amb_pkg::RESP_SLVERR;
				end
			endcase
		end
		// An event in the same cycle as its clear stays set.
		d.stat        = (q.stat & ~wclr) | ev;
		d.irq         = |(d.stat & d.mask);
		d.rsp.awready = ~d.aw_got & ~d.rsp.bvalid;
		d.rsp.wready  = ~d.w_got & ~d.rsp.bvalid;

		if (q.rsp.rvalid && axi_req_i.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (q.rsp.arready && axi_req_i.arvalid) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rdata  = 32'h0000_0000;
			d.rsp.rresp  = amb_pkg::RESP_OKAY;
			unique case (axi_req_i.araddr)
				amb_pkg::OFF_CTRL: begin
					d.rsp.rdata[amb_pkg::CTRL_EN_BIT] = q.ctrl_en;
				end
				amb_pkg::OFF_STAT: begin
					d.rsp.rdata[amb_pkg::EV_W-1:0] = q.stat;
				end
				amb_pkg::OFF_MASK: begin
					d.rsp.rdata[amb_pkg::EV_W-1:0] = q.mask;
				end
				amb_pkg::OFF_STATE: begin
					d.rsp.rdata[amb_pkg::STATE_RES_LSB +: 8]  = q.result;
					d.rsp.rdata[amb_pkg::STATE_ADDR_LSB +: 5] = q.addr;
					d.rsp.rdata[amb_pkg::STATE_BUSY_BIT]      = (q.st != amb_pkg::ST_IDLE);
					d.rsp.rdata[amb_pkg::STATE_DONE_BIT]      = q.done_n;
				end
				default: begin
					d.rsp.rresp = amb_pkg::RESP_SLVERR;
				end
			endcase
		end
		d.rsp.arready = ~d.rsp.rvalid;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q             <= '0;
			q.cs_n        <= 1'b1;
			q.wr_n        <= 1'b1;
			q.rd_n        <= 1'b1;
			q.done_n      <= 1'b1;
			q.st          <= amb_pkg::ST_IDLE;
			q.ctrl_en     <= amb_pkg::CTRL_EN_RST;
			q.mask        <= amb_pkg::MASK_RST;
		end else begin
			q <= d;
		end
	end

	assign axi_rsp_o           = q.rsp;
	assign bus_data_lines_o    = q.db;
	assign bus_data_lines_oe_o = q.db_oe;
	assign conversion_done_n_o = q.done_n;
	assign irq_o               = q.irq;

endmodule // amb_core

// ### verilog/amb_mux_decode.sv
// Decoder from the latched mux address to the positive and negative input selections.
module amb_mux_decode (
	input  wire logic [4:0] mux_address_bits_i,
	output logic [2:0]      pos_sel_o,
	output logic [2:0]      neg_sel_o
);

	logic [1:0] lo;
	logic [2:0] odd_ch;
	logic [2:0] even_ch;

	// Bit 4 only exists on the wider part; the four-input selector ignores it.
	always_comb begin
		lo      = mux_address_bits_i[1:0];
		odd_ch  = {1'b0, mux_address_bits_i[1], 1'b0};
		even_ch = {1'b0, mux_address_bits_i[1], 1'b1};
		if (!mux_address_bits_i[2]) begin
			pos_sel_o = mux_address_bits_i[0] ? even_ch : odd_ch;
			neg_sel_o = mux_address_bits_i[0] ? odd_ch : even_ch;
		end else if (!mux_address_bits_i[3]) begin
			pos_sel_o = {1'b0, lo};
			neg_sel_o = amb_pkg::SEL_GND;
		end else if (lo == 2'h3) begin
			// Both sides on input 4 give a steady zero code for the unused code.
			pos_sel_o = amb_pkg::SEL_IN4;
			neg_sel_o = amb_pkg::SEL_IN4;
		end else begin
			pos_sel_o = {1'b0, lo};
			neg_sel_o = amb_pkg::SEL_IN4;
		end
	end

endmodule // amb_mux_decode

// ### verilog/amb_pkg.sv
// Shared constants, types and carriers of the converter bus interface.
package amb_pkg;

	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned CONV_TIME_NS  = 40000;
	localparam int unsigned CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned SAR_PERIODS   = 9;
	localparam int unsigned SYNC_W        = 51;

	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_STAT  = 8'h04;
	localparam logic [7:0] OFF_MASK  = 8'h08;
	localparam logic [7:0] OFF_STATE = 8'h0c;

	localparam int unsigned EV_DONE        = 0;
	localparam int unsigned EV_READ        = 1;
	localparam int unsigned EV_START       = 2;
	localparam int unsigned EV_W           = 3;
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned STATE_RES_LSB  = 0;
	localparam int unsigned STATE_ADDR_LSB = 8;
	localparam int unsigned STATE_BUSY_BIT = 16;
	localparam int unsigned STATE_DONE_BIT = 17;

	localparam logic            CTRL_EN_RST = 1'b1;
	localparam logic [2:0]      MASK_RST    = 3'h0;
	localparam logic [SYNC_W-1:0] SYNC_RST  = {3'h7, 48'h0};

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [2:0] SEL_IN1 = 3'h0;
	localparam logic [2:0] SEL_IN4 = 3'h3;
	localparam logic [2:0] SEL_GND = 3'h4;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_RESOLVE = 2'b11,
		ST_LOAD    = 2'b10
	} amb_state_t;

	typedef struct packed {
		logic [3:0][7:0] ch;
		logic [7:0]      gnd;
	} amb_analog_t;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} amb_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} amb_axi_rsp_t;

endpackage // amb_pkg

// ### verilog/amb_sync.sv
// Two-stage synchroniser for inputs that arrive from outside the clock domain.
module amb_sync #(
	parameter int unsigned     W   = 1,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] d_i,
	output logic [W-1:0]      q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} amb_sync_state_t;

	amb_sync_state_t q;
	amb_sync_state_t d;

	// The first stage feeds only the second one.
	always_comb begin
		d    = q;
		d.s1 = d_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q.s1 <= RST;
			q.s2 <= RST;
		end else begin
			q <= d;
		end
	end

	assign q_o = q.s2;

endmodule // amb_sync
